/* test/sps_board_model.sv */
`timescale 1ns/1ps
module sps_board_model #(
  parameter int IO_GOOD_DELAY = 8,
  parameter int RAMP_CYCLES = 6,
  parameter int TICK_PERIOD = 4
) (
  input wire logic clk,
  input wire logic core_power_enable,
  input wire logic [7:0] wake_req,
  output logic io_supply_good,
  output logic core_supply_ok,
  output logic [7:0] gpio_in,
  output logic osc_tick
);
  int up_cnt;
  int ramp_cnt;
  int tick_cnt;

  initial begin
    up_cnt = 0;
    ramp_cnt = 0;
    tick_cnt = 0;
    io_supply_good = 1'b0;
    core_supply_ok = 1'b0;
    osc_tick = 1'b0;
  end

  // The I/O rail comes up once after power-on and then stays up.
  always @(posedge clk) begin
    if (up_cnt < IO_GOOD_DELAY) begin
      up_cnt <= up_cnt + 1;
    end
    io_supply_good <= (up_cnt >= IO_GOOD_DELAY);
  end

  // The core rail ramps well inside the settle delay the bench programs.
  always @(posedge clk) begin
    if (!core_power_enable) begin
      ramp_cnt <= 0;
      core_supply_ok <= 1'b0;
    end else if (ramp_cnt < RAMP_CYCLES) begin
      ramp_cnt <= ramp_cnt + 1;
    end else begin
      core_supply_ok <= 1'b1;
    end
  end

  // The slow oscillator runs free, in Sleep as well.
  always @(posedge clk) begin
    tick_cnt <= (tick_cnt == TICK_PERIOD - 1) ? 0 : tick_cnt + 1;
    osc_tick <= (tick_cnt == 0);
  end

  assign gpio_in = wake_req;
endmodule

/* test/sps_sequencer_tb.sv */
`timescale 1ns/1ps
module sps_sequencer_tb;
  localparam logic [31:0] SETTLE = 32'h00000014;
  logic clk, rst, hw_reset, ce, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, boot_vector;
  logic io_good, core_ok, osc_tick, halt_req, halt_snoop, irq;
  logic [2:0] halt_cached;
  logic [7:0] gpio_in, wake_req;
  logic cpe, cpu_clk_en, cpu_reset, snoop_en, irq_taken, sys_regs_reset;
  logic cache_inval, fast_tick_en;
  int num_errors = 0;
  int samples_checked = 0;
  int srr_count = 0;

  sps_board_model board (.clk(clk), .core_power_enable(cpe),
    .wake_req(wake_req), .io_supply_good(io_good),
    .core_supply_ok(core_ok), .gpio_in(gpio_in), .osc_tick(osc_tick));

  sps_sequencer #(.SETTLE_CYCLES(SETTLE)) DUT (.CLK(clk), .RST(rst),
    .CE(ce), .HW_RESET(hw_reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IO_SUPPLY_GOOD(io_good),
    .GPIO_IN(gpio_in), .OSC_TICK(osc_tick), .HALT_REQ(halt_req),
    .HALT_SNOOP(halt_snoop), .HALT_CACHED(halt_cached), .IRQ(irq),
    .CORE_POWER_ENABLE(cpe), .CPU_CLK_EN(cpu_clk_en),
    .CPU_RESET(cpu_reset), .SNOOP_EN(snoop_en), .IRQ_TAKEN(irq_taken),
    .SYS_REGS_RESET(sys_regs_reset), .CACHE_INVALIDATE(cache_inval),
    .FAST_TICK_EN(fast_tick_en), .BOOT_VECTOR(boot_vector));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (sys_regs_reset === 1'b1) begin
      srr_count <= srr_count + 1;
    end
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    num_errors++;
    $display("CHECK FAILED %s expected response seen timeout", what);
    report_and_stop();
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    check("pslverr", pslverr, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) timeout("pready");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
    logic [31:0] x;
    apb(1'b0, a, 32'h00000000, x);
    check(what, x, exp);
  endtask

  // Returns the number of edges until the chosen output is sampled at v.
  task automatic wait_for(input int sel, input logic v, input int bound,
                          output int n);
    logic s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      case (sel)
        0: s = cpe;
        1: s = cpu_clk_en;
        2: s = cpu_reset;
        3: s = irq_taken;
        default: s = io_good;
      endcase
    end while (s !== v && n < bound);
    if (s !== v) timeout("wait");
  endtask

  task automatic do_reset(input logic hw);
    rst <= 1'b1;
    hw_reset <= hw;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    hw_reset <= 1'b0;
  endtask

  task automatic enter_sleep(input logic [8:0] mask);
    int n;
    // No peripheral model here; a peripheral is reset before its clock stops.
    wr(sps_pkg::ADDR_SLEEP_POWER_PREP, 32'h00000001);
    wr(sps_pkg::ADDR_WAKE_CAUSE, 32'h00000000);
    wr(sps_pkg::ADDR_WAKE_MASK, {23'h000000, mask});
    wr(sps_pkg::ADDR_SLEEP_REQUEST, 32'h00000001);
    wait_for(0, 1'b0, 10, n);
    @(posedge clk);
    check("cache invalidate", cache_inval, 1'b1);
    check("fast tick", fast_tick_en, 1'b0);
  endtask

  task automatic finish_wake(input logic [31:0] exp, input logic [31:0] m);
    int n;
    int srr0;
    logic [31:0] x;
    wait_for(0, 1'b1, 400, n);
    wake_req <= 8'h00;
    srr0 = srr_count;
    check("cpu reset in settle", cpu_reset, 1'b1);
    wait_for(2, 1'b0, 60, n);
    check("settle", n >= SETTLE - 1 && n <= SETTLE + 3, 1'b1);
    check("core rail", core_ok, 1'b1);
    repeat (2) @(posedge clk);
    check("regs reset pulse", srr_count - srr0, 32'h1);
    check("boot vector", boot_vector, 32'h1fc00000);
    apb(1'b0, sps_pkg::ADDR_WAKE_CAUSE, 32'h00000000, x);
    check("wake cause", x & m, exp);
    wr(sps_pkg::ADDR_WAKE_CAUSE, 32'h00000001);
    rd_chk("cause cleared", sps_pkg::ADDR_WAKE_CAUSE, 32'h0);
    rd_chk("mask default", sps_pkg::ADDR_WAKE_MASK, 32'h0);
    rd_chk("settle default", sps_pkg::ADDR_POWER_CTRL, SETTLE);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic test_reset_values();
    int n;
    wait_for(5, 1'b1, 40, n);
    check("enable before io good", cpe, 1'b0);
    wait_for(0, 1'b1, 3, n);
    check("enable after io good", n <= 2, 1'b1);
    check("boot vector", boot_vector, 32'h1fc00000);
    rd_chk("pin enable", sps_pkg::ADDR_WAKE_PIN_INPUT_ENABLE, 32'h0);
    rd_chk("unmapped", 12'h3fc, 32'h0);
    rd_chk("mask reset", sps_pkg::ADDR_WAKE_MASK, 32'h0);
    rd_chk("settle reset", sps_pkg::ADDR_POWER_CTRL, SETTLE);
    $display("reset values test done");
  endtask

  task automatic test_idle(input logic snoop);
    int n;
    int m;
    halt_snoop <= snoop;
    halt_cached <= 3'h3;
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    repeat (3) @(posedge clk);
    check("short tail", cpu_clk_en, 1'b1);
    halt_cached <= 3'h4;
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    repeat (3) @(posedge clk);
    check("idle clock", cpu_clk_en, 1'b0);
    check("idle snoop", snoop_en, snoop);
    irq <= 1'b1;
    wait_for(1, 1'b1, 30, n);
    check("restart", n - 1 >= 5 && n - 1 <= 10, 1'b1);
    wait_for(3, 1'b1, 30, m);
    check("exit", n + m - 1 <= 20, 1'b1);
    irq <= 1'b0;
    repeat (2) @(posedge clk);
    $display("idle test done");
  endtask

  task automatic test_tod_wake();
    logic [31:0] c0;
    logic [31:0] c1;
    apb(1'b0, sps_pkg::ADDR_TOD_COUNT, 32'h0, c0);
    wr(sps_pkg::ADDR_TOD_MATCH_TWO, c0 + 32'h40);
    wr(sps_pkg::ADDR_CNTR_CTRL, 32'h00000001);
    apb(1'b0, sps_pkg::ADDR_TOD_COUNT, 32'h0, c1);
    wake_req <= 8'h02;
    repeat (10) @(posedge clk);
    wake_req <= 8'h00;
    apb(1'b0, sps_pkg::ADDR_TOD_COUNT, 32'h0, c0);
    check("bypass gated", c0, c1);
    wr(sps_pkg::ADDR_CNTR_CTRL, 32'h00000000);
    apb(1'b0, sps_pkg::ADDR_TOD_COUNT, 32'h0, c0);
    c0 = c0 - 32'h4;
    enter_sleep(9'h1ff);
    wake_req <= 8'h04;
    repeat (40) @(posedge clk);
    check("pins not enabled", cpe, 1'b0);
    wake_req <= 8'h00;
    finish_wake(32'h00000300, 32'h00000300);
    apb(1'b0, sps_pkg::ADDR_TOD_COUNT, 32'h0, c1);
    check("tod ran", c1 >= c0 + 32'h40, 1'b1);
    $display("time match wake test done");
  endtask

  task automatic test_gpio_wake();
    logic [31:0] c0;
    logic [31:0] c1;
    wr(sps_pkg::ADDR_WAKE_PIN_INPUT_ENABLE, 32'h00000000);
    rd_chk("write only", sps_pkg::ADDR_WAKE_PIN_INPUT_ENABLE, 32'h0);
    do_reset(1'b0);
    wr(sps_pkg::ADDR_CNTR_CTRL, 32'h00000001);
    apb(1'b0, sps_pkg::ADDR_TOD_COUNT, 32'h0, c0);
    wake_req <= 8'h02;
    repeat (10) @(posedge clk);
    wake_req <= 8'h00;
    apb(1'b0, sps_pkg::ADDR_TOD_COUNT, 32'h0, c1);
    check("bypass ticks", c1 - c0, 32'h0000000a);
    wr(sps_pkg::ADDR_CNTR_CTRL, 32'h00000000);
    enter_sleep(9'h004);
    wake_req <= 8'h20;
    repeat (30) @(posedge clk);
    check("unmasked pin", cpe, 1'b0);
    wake_req <= 8'h04;
    finish_wake(32'h00000204, 32'h00000204);
    enter_sleep(9'h080);
    wake_req <= 8'h80;
    finish_wake(32'h00000280, 32'hffffffff);
    $display("pin wake test done");
  endtask

  initial begin
    rst = 1'b1;
    hw_reset = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    halt_req = 1'b0;
    halt_snoop = 1'b0;
    halt_cached = 3'h0;
    irq = 1'b0;
    wake_req = 8'h00;
    do_reset(1'b1);
    test_reset_values();
    test_idle(1'b0);
    test_idle(1'b1);
    test_tod_wake();
    test_gpio_wake();
    report_and_stop();
  end
endmodule

/* verilog/sps_ctrl_if.sv */
`timescale 1ns/1ps
interface sps_ctrl_if;
  logic clear_causes;
  logic [8:0] wake_mask;
  logic wake_gpio_armed;
  logic sleeping;
  logic [8:0] causes;
  logic leaving_sleep;
  modport seq (input clear_causes, input wake_mask, input wake_gpio_armed,
               input sleeping, output causes, output leaving_sleep);
  modport top (output clear_causes, output wake_mask,
               output wake_gpio_armed, output sleeping, input causes,
               input leaving_sleep);
endinterface

/* verilog/sps_pkg.sv */
package sps_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ------------------------------------------------------------------
  localparam logic [11:0] ADDR_WAKE_PIN_INPUT_ENABLE = 12'h110;
  localparam logic [11:0] ADDR_SLEEP_POWER_PREP = 12'h200;
  localparam logic [11:0] ADDR_SLEEP_REQUEST = 12'h204;
  localparam logic [11:0] ADDR_WAKE_MASK = 12'h208;
  localparam logic [11:0] ADDR_WAKE_CAUSE = 12'h20c;
  localparam logic [11:0] ADDR_POWER_CTRL = 12'h210;
  localparam logic [11:0] ADDR_SEQ_STATUS = 12'h214;
  localparam logic [11:0] ADDR_TOD_MATCH_TWO = 12'h218;
  localparam logic [11:0] ADDR_TOD_COUNT = 12'h21c;
  localparam logic [11:0] ADDR_CNTR_CTRL = 12'h220;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int WMASK_GPIO_LSB = 0;
  localparam int WMASK_TOD = 8;
  localparam int WCAUSE_SLEEP = 9;
  localparam int CNTR_OSC_BYPASS = 0;

  // ------------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------------
  localparam logic [8:0] WAKE_MASK_RESET = 9'h000;
  localparam int CLK_HZ = 25000000;
  localparam int SETTLE_DEFAULT_MS = 20;
  localparam int SETTLE_DEFAULT_CYC = SETTLE_DEFAULT_MS * (CLK_HZ / 1000);
  localparam logic [31:0] SETTLE_RESET = 32'(SETTLE_DEFAULT_CYC);
  localparam int IDLE_RESTART_MIN = 5;
  localparam int IDLE_RESTART_MAX = 10;
  localparam int IDLE_RECOGNISE = 10;
  localparam int IDLE_EXIT_MAX = 20;
  localparam logic [4:0] IDLE_RESTART_CYC = 5'(IDLE_RESTART_MIN + 1);
  localparam logic [4:0] IDLE_RECOG_CYC = 5'(IDLE_RECOGNISE);
  localparam int CACHE_TAIL_INSNS = 4;
  localparam logic [31:0] RESET_VECTOR = 32'h1fc00000;

  typedef enum logic [2:0] {
    SPS_RUN,
    SPS_IDLE,
    SPS_RESTART,
    SPS_RECOG,
    SPS_SLEEP,
    SPS_SETTLE
  } sps_state_type;

endpackage

/* verilog/sps_sequencer.sv */
// Implementation choice: the APB register port.
`timescale 1ns/1ps
// Contract
// - GPIO 7:0 wake only after any write to the wake input enable.
// - Wake input enable survives Sleep and runtime reset; hardware reset clears.
// - Wake input enable is 32-bit write-only; value ignored, reads zero.
// - Bypass pin clocks counters in Sleep only after enable write.
// - Snooping idle keeps bus snoop; non-snooping idle stops it.
// - Idle entry needs halt and next four instructions cached.
// - Interrupt in idle restarts CPU clocks within five to ten clocks.
// - Ten more clocks to recognise interrupt; exit at most twenty.
// - Only masked GPIO 7:0 or time match two wake from Sleep.
// - Sleep loses non-system registers and cache contents.
// - Time-of-year counter runs in Sleep; fast tick counter stops.
// - Entering Sleep deasserts core power enable.
// - Core power enable asserts once I/O supply good asserts.
// - On wake raise power enable, wait settle delay; board stabilises.
// - After settle delay CPU starts at reset vector 0x1FC00000.
// - After wake, system control registers return to defaults.
// - Wake cause reports leaving Sleep and source; write clears.
// - Settle delay defaults to twenty milliseconds.
module sps_sequencer #(
  parameter logic [31:0] SETTLE_CYCLES = sps_pkg::SETTLE_RESET
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic HW_RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic IO_SUPPLY_GOOD,
  input wire logic [7:0] GPIO_IN,
  input wire logic OSC_TICK,
  input wire logic HALT_REQ,
  input wire logic HALT_SNOOP,
  input wire logic [2:0] HALT_CACHED,
  input wire logic IRQ,
  output logic CORE_POWER_ENABLE,
  output logic CPU_CLK_EN,
  output logic CPU_RESET,
  output logic SNOOP_EN,
  output logic IRQ_TAKEN,
  output logic SYS_REGS_RESET,
  output logic CACHE_INVALIDATE,
  output logic FAST_TICK_EN,
  output logic [31:0] BOOT_VECTOR
);
  sps_ctrl_if ctl ();

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic pin_en_q;
  logic [8:0] wmask_q;
  logic [31:0] settle_q;
  logic [31:0] tod_match_q;
  logic [31:0] tod_q;
  logic bypass_q;
  logic prep_q;
  logic sleep_req_q;
  logic clr_q;
  sps_pkg::sps_state_type state_q;
  logic [31:0] cnt_q;
  logic [4:0] idle_cnt_q;
  logic setup;
  logic wr;
  logic rd;
  logic tod_tick;
  logic tod_hit;
  logic in_sleep;

  assign setup = PSEL & ~PENABLE;
  assign wr = PSEL & PENABLE & PWRITE & PREADY & CE;
  assign rd = setup & ~PWRITE;
  assign in_sleep = state_q == sps_pkg::SPS_SLEEP;
  // Bypass pin drives the counter only once inputs are enabled.
  assign tod_tick = bypass_q ? (GPIO_IN[1] & pin_en_q) : OSC_TICK;
  assign tod_hit = tod_q == tod_match_q;

  assign ctl.clear_causes = clr_q;
  assign ctl.wake_mask = wmask_q;
  assign ctl.wake_gpio_armed = pin_en_q;
  assign ctl.sleeping = in_sleep;

  sps_wake_cause u_cause (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .gpio_in(GPIO_IN),
    .tod_hit(tod_hit),
    .ctl(ctl)
  );

  // ------------------------------------------------------------------
  // APB slave, one wait-free access phase
  // ------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY <= setup;
      PSLVERR <= 1'b0;
    end
  end

  // Only a hardware reset clears this latch; Sleep and RST do not.
  always_ff @(posedge CLK) begin
    if (HW_RESET) begin
      pin_en_q <= 1'b0;
    end else if (wr && PADDR == sps_pkg::ADDR_WAKE_PIN_INPUT_ENABLE) begin
      pin_en_q <= 1'b1;
    end
  end

  // System control registers return to defaults on reset or on wake.
  always_ff @(posedge CLK) begin
    if (RST || SYS_REGS_RESET) begin
      wmask_q <= sps_pkg::WAKE_MASK_RESET;
      settle_q <= SETTLE_CYCLES;
      tod_match_q <= 32'h00000000;
      bypass_q <= 1'b0;
      prep_q <= 1'b0;
    end else if (wr) begin
      unique case (PADDR)
        sps_pkg::ADDR_WAKE_MASK: wmask_q <= PWDATA[8:0];
        sps_pkg::ADDR_POWER_CTRL: settle_q <= PWDATA;
        sps_pkg::ADDR_TOD_MATCH_TWO: tod_match_q <= PWDATA;
        sps_pkg::ADDR_CNTR_CTRL: bypass_q <= PWDATA[sps_pkg::CNTR_OSC_BYPASS];
        sps_pkg::ADDR_SLEEP_POWER_PREP: prep_q <= 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      sleep_req_q <= 1'b0;
      clr_q <= 1'b0;
    end else if (CE) begin
      sleep_req_q <= wr && PADDR == sps_pkg::ADDR_SLEEP_REQUEST;
      clr_q <= wr && PADDR == sps_pkg::ADDR_WAKE_CAUSE;
    end
  end

  // The counter keeps running in every state, Sleep included.
  always_ff @(posedge CLK) begin
    if (HW_RESET) begin
      tod_q <= 32'h00000000;
    end else if (CE && wr && PADDR == sps_pkg::ADDR_TOD_COUNT) begin
      tod_q <= PWDATA;
    end else if (CE && tod_tick) begin
      tod_q <= tod_q + 32'h00000001;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
    end else if (CE && rd) begin
      unique case (PADDR)
        sps_pkg::ADDR_WAKE_MASK: PRDATA <= {23'h000000, wmask_q};
        sps_pkg::ADDR_WAKE_CAUSE:
          PRDATA <= {22'h000000, ctl.leaving_sleep, ctl.causes};
        sps_pkg::ADDR_POWER_CTRL: PRDATA <= settle_q;
        sps_pkg::ADDR_SEQ_STATUS: PRDATA <= {29'h00000000, state_q};
        sps_pkg::ADDR_TOD_MATCH_TWO: PRDATA <= tod_match_q;
        sps_pkg::ADDR_TOD_COUNT: PRDATA <= tod_q;
        sps_pkg::ADDR_CNTR_CTRL: PRDATA <= {31'h00000000, bypass_q};
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Power and idle sequencer
  // ------------------------------------------------------------------
  // Sleep is accepted only after the power preparation write, since an
  // unprepared board may not tolerate losing the core supply.
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= sps_pkg::SPS_RUN;
      cnt_q <= 32'h00000000;
      idle_cnt_q <= 5'h00;
    end else if (CE) begin
      unique case (state_q)
        sps_pkg::SPS_RUN: begin
          if (sleep_req_q && prep_q) begin
            state_q <= sps_pkg::SPS_SLEEP;
          end else if (HALT_REQ && !IRQ &&
                       HALT_CACHED >= 3'(sps_pkg::CACHE_TAIL_INSNS)) begin
            state_q <= sps_pkg::SPS_IDLE;
          end
        end
        sps_pkg::SPS_IDLE: begin
          if (IRQ) begin
            state_q <= sps_pkg::SPS_RESTART;
            idle_cnt_q <= 5'h01;
          end
        end
        sps_pkg::SPS_RESTART: begin
          idle_cnt_q <= idle_cnt_q + 5'h01;
          if (idle_cnt_q == sps_pkg::IDLE_RESTART_CYC - 5'h01) begin
            state_q <= sps_pkg::SPS_RECOG;
            idle_cnt_q <= 5'h01;
          end
        end
        sps_pkg::SPS_RECOG: begin
          idle_cnt_q <= idle_cnt_q + 5'h01;
          if (idle_cnt_q == sps_pkg::IDLE_RECOG_CYC) begin
            state_q <= sps_pkg::SPS_RUN;
          end
        end
        sps_pkg::SPS_SLEEP: begin
          if (|(wmask_q & {tod_hit, GPIO_IN & {8{pin_en_q}}})) begin
            state_q <= sps_pkg::SPS_SETTLE;
            cnt_q <= settle_q;
          end
        end
        sps_pkg::SPS_SETTLE: begin
          if (cnt_q <= 32'h00000001) begin
            state_q <= sps_pkg::SPS_RUN;
          end else begin
            cnt_q <= cnt_q - 32'h00000001;
          end
        end
        default: state_q <= sps_pkg::SPS_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      CORE_POWER_ENABLE <= 1'b0;
      CPU_CLK_EN <= 1'b1;
      CPU_RESET <= 1'b1;
      SNOOP_EN <= 1'b1;
      IRQ_TAKEN <= 1'b0;
      SYS_REGS_RESET <= 1'b0;
      CACHE_INVALIDATE <= 1'b0;
      FAST_TICK_EN <= 1'b0;
      BOOT_VECTOR <= sps_pkg::RESET_VECTOR;
    end else if (CE) begin
      CORE_POWER_ENABLE <= IO_SUPPLY_GOOD && state_q != sps_pkg::SPS_SLEEP;
      CPU_CLK_EN <= !(state_q inside {sps_pkg::SPS_IDLE, sps_pkg::SPS_RESTART,
                                    sps_pkg::SPS_SLEEP});
      CPU_RESET <= !IO_SUPPLY_GOOD || state_q inside {sps_pkg::SPS_SLEEP,
                                                     sps_pkg::SPS_SETTLE};
      SNOOP_EN <= !(state_q == sps_pkg::SPS_IDLE && !HALT_SNOOP)
                  && !in_sleep;
      IRQ_TAKEN <= state_q == sps_pkg::SPS_RECOG
                   && idle_cnt_q == sps_pkg::IDLE_RECOG_CYC;
      SYS_REGS_RESET <= state_q == sps_pkg::SPS_SETTLE
                        && cnt_q <= 32'h00000001;
      CACHE_INVALIDATE <= in_sleep;
      FAST_TICK_EN <= !in_sleep && IO_SUPPLY_GOOD;
      BOOT_VECTOR <= sps_pkg::RESET_VECTOR;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_idle_irq;
    CE && state_q == sps_pkg::SPS_IDLE && IRQ;
  endsequence
  sequence s_clk_back;
    ##[5:10] CPU_CLK_EN;
  endsequence
  property p_idle_restart;
    @(posedge CLK) disable iff (RST || !CE) s_idle_irq |-> s_clk_back;
  endproperty
  a_idle_restart: assert property (p_idle_restart)
    else $error("idle clock restart outside five to ten cycles");

  property p_idle_exit;
    @(posedge CLK) disable iff (RST || !CE) s_idle_irq |-> ##[15:20] IRQ_TAKEN;
  endproperty
  a_idle_exit: assert property (p_idle_exit)
    else $error("idle exit exceeded twenty cycles");

  property p_sleep_pwr;
    @(posedge CLK) disable iff (RST || !CE)
      state_q == sps_pkg::SPS_SLEEP |=> !CORE_POWER_ENABLE;
  endproperty
  a_sleep_pwr: assert property (p_sleep_pwr)
    else $error("power enable high in sleep");

  property p_settle_hold;
    @(posedge CLK) disable iff (RST || !CE)
      state_q == sps_pkg::SPS_SETTLE |=> CPU_RESET;
  endproperty
  a_settle_hold: assert property (p_settle_hold)
    else $error("cpu released during settle");

  property p_gpio_gate;
    @(posedge CLK) disable iff (RST || !CE)
      in_sleep && !pin_en_q && !(wmask_q[8] && tod_hit) |=> in_sleep;
  endproperty
  a_gpio_gate: assert property (p_gpio_gate)
    else $error("gpio wake without input enable");

  property p_pin_keep;
    @(posedge CLK) !HW_RESET && pin_en_q |=> pin_en_q;
  endproperty
  a_pin_keep: assert property (p_pin_keep)
    else $error("wake input enable lost");

  property p_nosnoop;
    @(posedge CLK) disable iff (RST || !CE)
      state_q == sps_pkg::SPS_IDLE && !HALT_SNOOP |=> !SNOOP_EN;
  endproperty
  a_nosnoop: assert property (p_nosnoop)
    else $error("snoop active in non-snooping idle");

  property p_power_on;
    @(posedge CLK) disable iff (RST || !CE)
      IO_SUPPLY_GOOD && state_q == sps_pkg::SPS_RUN |=> CORE_POWER_ENABLE;
  endproperty
  a_power_on: assert property (p_power_on)
    else $error("power enable not asserted");

  property p_vector;
    @(posedge CLK) disable iff (RST)
      $fell(CPU_RESET) |-> BOOT_VECTOR == sps_pkg::RESET_VECTOR;
  endproperty
  a_vector: assert property (p_vector)
    else $error("wrong boot vector");
endmodule

/* verilog/sps_wake_cause.sv */
`timescale 1ns/1ps
module sps_wake_cause (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] gpio_in,
  input wire logic tod_hit,
  sps_ctrl_if.seq ctl
);
  logic [8:0] src;
  logic [8:0] hit;
  logic [8:0] causes_q;
  logic leaving_q;

  assign src = {tod_hit, gpio_in & {8{ctl.wake_gpio_armed}}};
  assign ctl.causes = causes_q;
  assign ctl.leaving_sleep = leaving_q;

  // --------------------------------------------------------------
  // Sticky causes: a new wake beats a software clear.
  // --------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 9; i++) begin : g_src
      assign hit[i] = ctl.sleeping & ctl.wake_mask[i] & src[i];
      always_ff @(posedge clk) begin
        if (rst) begin
          causes_q[i] <= 1'b0;
        end else if (ce) begin
          if (hit[i]) begin
            causes_q[i] <= 1'b1;
          end else if (ctl.clear_causes) begin
            causes_q[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      leaving_q <= 1'b0;
    end else if (ce) begin
      if (|hit) begin
        leaving_q <= 1'b1;
      end else if (ctl.clear_causes) begin
        leaving_q <= 1'b0;
      end
    end
  end

  property p_cause_sticky;
    @(posedge clk) disable iff (rst) ce && (|hit) |=> leaving_q;
  endproperty
  a_cause_sticky: assert property (p_cause_sticky)
    else $error("wake cause not recorded");
endmodule
